// ==== hw/on_demand_dma_request_interface.sv ====
/*
 * request side of the on-demand transfer mode: bus release handshake,
 * command word decode, channel 0 request, channel 1..3 queues,
 * transfer end, queue clear, address error and freeze handling.
 * assumes the dma engine reports run status and completion pulses,
 * and all inputs are synchronous to sys_clk.
 */
`timescale 1ns/100ps
`include "ondemand_defines.svh"

// Summary of operation
// R1 - channel 0, mode 0, size 0 command is a channel 0 transfer request
// R2 - channel 1..3 commands are queued; mode and size ignored
// R3 - queue clear flushes channel 0 request, all queues, external requests
// R4 - transfer end clears channel 0 enable; addresses and count kept
// R5 - transfer end refused while channel 0 transfer runs
// R6 - no new channel 0 request until accepted one completes
// R7 - channels 1..3 queue four requests; extra ones dropped
// R8 - controller must not send to a full queue
// R9 - queued requests survive a completion with transfer end flag set
// R10 - channel 0 with nonzero mode raises address error until cleared
// R11 - strobe alone repeats request to last requested channel
// R12 - strobe alone as first request after reset is ignored
// R13 - software clears transfer end flag before strobe-only repeat
// R14 - release request with strobe is direct channel 2 request, no grant
// R15 - direct channel 2 accepted during repeats when queue has room
// R16 - channel 0 request during channel 0 bus cycle is dropped
// R17 - queue clear also releases freeze
// R18 - controller waits for bus-available before next release request
// R19 - bus-available one cycle, stretched to precharge time on row miss
// R20 - release request takes a cycle; ignored if row miss drives grant
// R21 - mode bit change during transfer freezes controller
// R22 - only the listed command encodings may be sent
// R23 - bus-available means data bus free two cycles later
// R24 - command word fields: size 31..29, channel 27..26, mode 25..24
// R25 - strobe alone is a repeat only if no grant two cycles before
// R26 - queues served first in first out, one per completion
module on_demand_dma_request_interface #(
    parameter int QDEPTH = `QUEUE_DEPTH
) (
    // clock and reset
    input  wire logic                        sys_clk,
    input  wire logic                        sys_rst,
    // link pins
    input  wire logic                        bus_release_request,
    input  wire logic                        xfer_request_pin,
    input  wire logic [31:0]                 cmdWord,
    output logic                             bus_available_out,
    // memory side row miss and precharge length
    input  wire logic                        rowMissAvail,
    // dma engine side
    input  wire ondemand_pkg::dma_status_type dmaStatus,
    input  wire logic                        ch0Done,
    input  wire logic [2:0]                  chDone,
    input  wire logic                        chTake,
    input  wire logic [1:0]                  chTakeSel,
    output ondemand_pkg::request_type        ch0Request,
    output logic [2:0]                       chPending,
    output logic [2:0]                       chFull,
    output logic                             channelEnableClear,
    output logic                             extRequestsFlush,
    // software control
    input  wire logic                        on_demand_mode_bit,
    input  wire logic                        addrErrorClear,
    output logic                             addr_error_flag,
    output logic                             frozen
);
    import ondemand_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // bus release handshake
    typedef enum logic [2:0] {
        IDLE_type_s  = 3'b001,
        ACCEPT_type_s = 3'b010,
        GRANT_type_s = 3'b100
    } grant_state_type;

    grant_state_type gState;
    grant_state_type next_gState;
    logic [2:0]      availHist;
    logic [2:0]      next_availHist;
    logic            directReq;
    logic            grantPulse;

    assign directReq = bus_release_request && xfer_request_pin; // R14

    always_comb begin
        next_gState = gState;
        grantPulse  = 1'b0;
        unique case (gState)
            IDLE_type_s: begin
                if (bus_release_request && !xfer_request_pin) begin
                    next_gState = ACCEPT_type_s;
                end
            end
            ACCEPT_type_s: begin
                // a row miss grant during acceptance swallows the request
                if (rowMissAvail) begin // R20
                    next_gState = IDLE_type_s;
                end else begin
                    next_gState = GRANT_type_s;
                end
            end
            GRANT_type_s: begin
                grantPulse  = 1'b1; // R19
                next_gState = IDLE_type_s;
            end
        endcase
        next_availHist = {availHist[1:0], bus_available_out};
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            gState    <= IDLE_type_s;
            availHist <= 3'h0;
        end else begin
            gState    <= next_gState;
            availHist <= next_availHist;
        end
    end

    // row miss stretches the grant for the precharge interval
    assign bus_available_out = grantPulse || rowMissAvail; // R19 R23

    ////////////////////////////////////////////////////////////////////
    // command decode
    logic [2:0] sizeCode;
    logic [1:0] chanNum;
    logic [1:0] reqMode;
    logic       cmdStrobe;
    logic       repeatStrobe;

    assign sizeCode = cmdWord[`SZ_MSB:`SZ_LSB]; // R24
    assign chanNum  = cmdWord[`CH_MSB:`CH_LSB];
    assign reqMode  = cmdWord[`MD_MSB:`MD_LSB];
    // strobe two cycles after a grant carries a command word
    assign cmdStrobe    = xfer_request_pin && !bus_release_request
                          && availHist[1]; // R25
    assign repeatStrobe = xfer_request_pin && !bus_release_request
                          && !availHist[1]; // R25 R11

    logic isCh0Req;
    logic isQClear;
    logic isXEnd;
    logic isAddrErr;
    assign isCh0Req  = cmdStrobe && chanNum == `CH_ZERO
                       && reqMode == `MD_HANDSHAKE
                       && sizeCode != `SZ_RSV5
                       && sizeCode != `SZ_QCLEAR
                       && sizeCode != `SZ_XEND; // R1
    assign isQClear  = cmdStrobe && chanNum == `CH_ZERO
                       && reqMode == `MD_QCLEAR
                       && sizeCode == `SZ_QCLEAR; // R3
    assign isXEnd    = cmdStrobe && chanNum == `CH_ZERO
                       && reqMode != `MD_HANDSHAKE
                       && sizeCode == `SZ_XEND; // R4
    assign isAddrErr = cmdStrobe && chanNum == `CH_ZERO
                       && reqMode != `MD_HANDSHAKE
                       && !isQClear && !isXEnd; // R10

    ////////////////////////////////////////////////////////////////////
    // channel 0, last channel memory, error and freeze
    logic       ch0Pend;
    logic       next_ch0Pend;
    logic       haveLast;
    logic       next_haveLast;
    logic [1:0] lastChan;
    logic [1:0] next_lastChan;
    logic       addrErr;
    logic       next_addrErr;
    logic       freeze;
    logic       next_freeze;
    logic       modePrev;
    logic       endClr;
    logic       next_endClr;
    logic       ch0Accept;
    logic [2:0] qPush;
    logic       repValid;

    assign repValid = repeatStrobe && haveLast && !freeze; // R12

    always_comb begin
        next_ch0Pend  = ch0Pend;
        next_haveLast = haveLast;
        next_lastChan = lastChan;
        next_addrErr  = addrErr;
        next_freeze   = freeze;
        next_endClr   = 1'b0;
        ch0Accept     = 1'b0;
        qPush         = 3'h0;
        if (ch0Done) begin
            next_ch0Pend = 1'b0;
        end
        // refused while pending or while a channel 0 bus cycle runs
        if (isCh0Req && !ch0Pend && !dmaStatus.busCycle0 && !freeze) begin
            ch0Accept = 1'b1; // R6 R16
        end
        if (cmdStrobe && chanNum != `CH_ZERO) begin
            qPush[chanNum - 2'h1] = 1'b1; // R2
            next_haveLast = 1'b1;
            next_lastChan = chanNum;
        end
        if (isCh0Req) begin
            next_haveLast = 1'b1;
            next_lastChan = `CH_ZERO;
        end
        if (repValid) begin
            if (lastChan == `CH_ZERO) begin
                if (dmaStatus.xferEndFlag0) begin
                    next_freeze = 1'b1; // R13
                end else if (!ch0Pend && !dmaStatus.busCycle0) begin
                    ch0Accept = 1'b1; // R11 R16
                end
            end else begin
                qPush[lastChan - 2'h1] = 1'b1; // R11
            end
        end
        if (directReq) begin
            qPush[1] = 1'b1; // R14 R15
        end
        if (ch0Accept) begin
            next_ch0Pend = 1'b1;
        end
        if (isXEnd && !dmaStatus.running0) begin
            next_endClr = 1'b1; // R4 R5
        end
        if (on_demand_mode_bit != modePrev && dmaStatus.anyRunning) begin
            next_freeze = 1'b1; // R21
        end
        if (addrErrorClear) begin
            next_addrErr = 1'b0;
        end
        if (isAddrErr) begin
            next_addrErr = 1'b1; // R10
        end
        if (isQClear) begin
            next_ch0Pend = 1'b0; // R3
            next_freeze  = 1'b0; // R17
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ch0Pend  <= 1'b0;
            haveLast <= 1'b0;
            lastChan <= 2'h0;
            addrErr  <= 1'b0;
            freeze   <= 1'b0;
            modePrev <= 1'b0;
            endClr   <= 1'b0;
        end else begin
            ch0Pend  <= next_ch0Pend;
            haveLast <= next_haveLast;
            lastChan <= next_lastChan;
            addrErr  <= next_addrErr;
            freeze   <= next_freeze;
            modePrev <= on_demand_mode_bit;
            endClr   <= next_endClr;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // channel 1..3 queues
    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : gQueue
            logic popThis;
            // completion pops, even with transfer end flag set
            assign popThis = chTake && chTakeSel == 2'(g + 1)
                             && chDone[g]; // R9 R26
            request_queue #(.DEPTH(QDEPTH)) uQueue (
                .sys_clk  (sys_clk),
                .sys_rst  (sys_rst),
                .push     (qPush[g] && !freeze),
                .pop      (popThis),
                .flush    (isQClear),
                .notEmpty (chPending[g]),
                .full     (chFull[g])
            );
        end
    endgenerate

    assign ch0Request.valid   = ch0Pend;
    assign ch0Request.channel = `CH_ZERO;
    assign channelEnableClear = endClr;
    assign extRequestsFlush   = isQClear; // R3
    assign addr_error_flag    = addrErr;
    assign frozen             = freeze;

    ////////////////////////////////////////////////////////////////////
    // checks
    property p_grant_one;
        @(posedge sys_clk) disable iff (sys_rst)
        $rose(bus_release_request) && !xfer_request_pin && gState == IDLE_type_s
        ##1 !rowMissAvail |=> bus_available_out;
    endproperty
    a_grant_one: assert property (p_grant_one) // R19
        else $error("no grant two cycles after release request");

    property p_direct_no_grant;
        @(posedge sys_clk) disable iff (sys_rst)
        directReq && gState == IDLE_type_s && !rowMissAvail
        |=> !grantPulse ##1 !grantPulse;
    endproperty
    a_direct_no_grant: assert property (p_direct_no_grant) // R14
        else $error("grant given to direct request");

    property p_xend_refused;
        @(posedge sys_clk) disable iff (sys_rst)
        isXEnd && dmaStatus.running0 |=> !channelEnableClear;
    endproperty
    a_xend_refused: assert property (p_xend_refused) // R5
        else $error("transfer end accepted during channel 0 run");

    property p_xend_taken;
        @(posedge sys_clk) disable iff (sys_rst)
        isXEnd && !dmaStatus.running0 |=> channelEnableClear;
    endproperty
    a_xend_taken: assert property (p_xend_taken) // R4
        else $error("transfer end not applied");

    property p_ch0_hold;
        @(posedge sys_clk) disable iff (sys_rst)
        ch0Request.valid && !ch0Done && !isQClear |=> ch0Request.valid;
    endproperty
    a_ch0_hold: assert property (p_ch0_hold) // R6
        else $error("channel 0 request lost before completion");

    property p_addr_err;
        @(posedge sys_clk) disable iff (sys_rst)
        isAddrErr |=> addr_error_flag;
    endproperty
    a_addr_err: assert property (p_addr_err) // R10
        else $error("address error not raised");

    property p_first_repeat;
        @(posedge sys_clk) disable iff (sys_rst)
        repeatStrobe && !haveLast |=> !ch0Request.valid || $past(ch0Pend);
    endproperty
    a_first_repeat: assert property (p_first_repeat) // R12
        else $error("strobe-only first request was acted on");

    property p_qclear;
        @(posedge sys_clk) disable iff (sys_rst)
        isQClear |=> !frozen && chPending == 3'h0 && !ch0Request.valid;
    endproperty
    a_qclear: assert property (p_qclear) // R3
        else $error("queue clear left state behind");

    property p_mode_freeze;
        @(posedge sys_clk) disable iff (sys_rst)
        on_demand_mode_bit != modePrev && dmaStatus.anyRunning
        && !isQClear |=> frozen;
    endproperty
    a_mode_freeze: assert property (p_mode_freeze) // R21
        else $error("mode change during transfer did not freeze");

    c_grant:  cover property (@(posedge sys_clk) grantPulse);
    c_ch0:    cover property (@(posedge sys_clk) ch0Accept);
    c_full:   cover property (@(posedge sys_clk) chFull[0]);
    c_freeze: cover property (@(posedge sys_clk) $rose(freeze));
endmodule

// ==== hw/ondemand_defines.svh ====
/*
 * timing counts, command word field positions and encodings
 * for the on-demand request interface.
 * assumes inclusion by bare name; definitions only.
 */
`ifndef ONDEMAND_DEFINES_SVH
`define ONDEMAND_DEFINES_SVH

`define SZ_MSB          31
`define SZ_LSB          29
`define CH_MSB          27
`define CH_LSB          26
`define MD_MSB          25
`define MD_LSB          24
`define SZ_HANDSHAKE    3'h0
`define SZ_QCLEAR       3'h6
`define SZ_XEND         3'h7
`define SZ_RSV5         3'h5
`define MD_HANDSHAKE    2'h0
`define MD_QCLEAR       2'h2
`define CH_ZERO         2'h0
`define CH_TWO          2'h2
`define QUEUE_DEPTH     4
`define BUS_FREE_DELAY  2
`define AVAIL_CYCLES    1
`define CLK_PERIOD_NS   20

`endif

// ==== hw/ondemand_pkg.sv ====
/*
 * types shared by the on-demand request interface.
 * assumes ondemand_defines.svh is on the include path.
 */
package ondemand_pkg;
    typedef struct packed {
        logic       valid;
        logic [1:0] channel;
    } request_type;

    typedef struct packed {
        logic       running0;
        logic       busCycle0;
        logic       anyRunning;
        logic       xferEndFlag0;
    } dma_status_type;
endpackage

// ==== hw/request_queue.sv ====
/*
 * small counting request queue for one channel; first in first out.
 * assumes pushes and pops come from the same clock domain.
 */
`timescale 1ns/100ps
`include "ondemand_defines.svh"

module request_queue #(
    parameter int DEPTH = `QUEUE_DEPTH
) (
    // clock and reset
    input  wire logic sys_clk,
    input  wire logic sys_rst,
    // control
    input  wire logic push,
    input  wire logic pop,
    input  wire logic flush,
    // status
    output logic      notEmpty,
    output logic      full
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [CW-1:0] level;
    logic [CW-1:0] next_level;
    logic          doPush;
    logic          doPop;

    always_comb begin
        doPush     = push && (level != CW'(DEPTH)); // R7
        doPop      = pop && (level != '0);           // R26
        next_level = level;
        if (flush) begin
            next_level = '0;
        end else if (doPush && !doPop) begin
            next_level = level + CW'(1);
        end else if (doPop && !doPush) begin
            next_level = level - CW'(1);
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            level <= '0;
        end else begin
            level <= next_level;
        end
    end

    assign notEmpty = (level != '0);
    assign full     = (level == CW'(DEPTH));

    property p_no_overflow;
        @(posedge sys_clk) disable iff (sys_rst)
        full && push && !pop && !flush |=> full;
    endproperty
    a_no_overflow: assert property (p_no_overflow) // R7
        else $error("queue level changed on push while full");
endmodule

// ==== tb/ext_ctrl_model.sv ====
/*
 * behavioural model of the external controller that issues requests:
 * bus release handshake with command word, strobe-only repeat and
 * direct channel 2 request.
 * assumes callers enter its tasks just after a rising edge of sys_clk.
 */
`timescale 1ns/100ps

module ext_ctrl_model (
    // clock
    input  wire logic        sys_clk,
    // link pins
    input  wire logic        bus_available_out,
    output logic             bus_release_request,
    output logic             xfer_request_pin,
    output logic [31:0]      cmdWord
);
    initial begin
        bus_release_request = 1'b0;
        xfer_request_pin    = 1'b0;
        cmdWord             = 32'h5A5A5A5A;
    end

    ////////////////////////////////////////////////////////////////////////
    // command word: request, wait for the grant, drive two cycles later
    task automatic send_cmd(input logic [31:0] word);
        int n;
        n = 0;
        bus_release_request = 1'b1;
        // no second request until this one is granted
        while (bus_available_out !== 1'b1 && n < 50) begin
            @(negedge sys_clk);
            n++;
        end
        @(posedge sys_clk);
        #1 bus_release_request = 1'b0;
        @(posedge sys_clk);
        #1 xfer_request_pin = 1'b1;
        cmdWord = word;
        @(posedge sys_clk);
        // released bus must not keep showing the last word
        #1 xfer_request_pin = 1'b0;
        cmdWord = ~word;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // release request held for one cycle only, no command follows
    task automatic release_pulse();
        bus_release_request = 1'b1;
        @(posedge sys_clk);
        #1 bus_release_request = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    // strobe alone, or strobe with release request for channel 2
    task automatic strobe_only(input logic withRelease);
        xfer_request_pin    = 1'b1;
        bus_release_request = withRelease;
        @(posedge sys_clk);
        #1 xfer_request_pin = 1'b0;
        bus_release_request = 1'b0;
    endtask
endmodule

// ==== tb/tb.sv ====
/*
 * self-checking bench for the on-demand request interface.
 * assumes the controller model drives the link pins and the bench
 * plays the dma engine, the memory side row miss and software.
 */
`timescale 1ns/100ps
`include "ondemand_defines.svh"

module tb;
    import ondemand_pkg::*;

    localparam int LIMIT = 4000;
    logic           sys_clk;
    logic           sys_rst;
    logic           rowMissAvail;
    logic           bus_release_request;
    logic           xfer_request_pin;
    logic [31:0]    cmdWord;
    logic           bus_available_out;
    dma_status_type dmaStatus;
    logic           ch0Done;
    logic [2:0]     chDone;
    logic           chTake;
    logic [1:0]     chTakeSel;
    request_type    ch0Request;
    logic [2:0]     chPending;
    logic [2:0]     chFull;
    logic           channelEnableClear;
    logic           extRequestsFlush;
    logic           on_demand_mode_bit;
    logic           addrErrorClear;
    logic           addr_error_flag;
    logic           frozen;
    int             errors = 0;
    int             n_tests = 0;
    int             cycles = 0;
    int             grants = 0;
    int             endClears = 0;
    int             flushes = 0;
    int             g0;

    always #(`CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;

    on_demand_dma_request_interface #(.QDEPTH(`QUEUE_DEPTH)) DUT (
        .sys_clk(sys_clk), .sys_rst(sys_rst),
        .bus_release_request(bus_release_request),
        .xfer_request_pin(xfer_request_pin), .cmdWord(cmdWord),
        .bus_available_out(bus_available_out), .rowMissAvail(rowMissAvail),
        .dmaStatus(dmaStatus), .ch0Done(ch0Done), .chDone(chDone),
        .chTake(chTake), .chTakeSel(chTakeSel), .ch0Request(ch0Request),
        .chPending(chPending), .chFull(chFull),
        .channelEnableClear(channelEnableClear),
        .extRequestsFlush(extRequestsFlush),
        .on_demand_mode_bit(on_demand_mode_bit),
        .addrErrorClear(addrErrorClear),
        .addr_error_flag(addr_error_flag), .frozen(frozen)
    );

    ext_ctrl_model u_ctrl (
        .sys_clk(sys_clk), .bus_available_out(bus_available_out),
        .bus_release_request(bus_release_request),
        .xfer_request_pin(xfer_request_pin), .cmdWord(cmdWord)
    );

    ////////////////////////////////////////////////////////////////////////
    // pulse counters, sampled mid-cycle where outputs are settled
    always @(negedge sys_clk) begin
        if (bus_available_out === 1'b1) grants++;
        if (channelEnableClear === 1'b1) endClears++;
        if (extRequestsFlush === 1'b1) flushes++;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            errors++;
            test_done();
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done();
        $display("comparisons %0d mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // n back-to-back completions, then one idle cycle
    task automatic pop(input logic [1:0] ch, input int n);
        chTake    = 1'b1;
        chTakeSel = ch;
        chDone    = 3'h1 << (ch - 2'h1);
        tick(n);
        chTake = 1'b0;
        chDone = 3'h0;
        tick(1);
    endtask

    task automatic done0();
        ch0Done = 1'b1;
        tick(1);
        ch0Done = 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        sys_clk            = 1'b0;
        sys_rst            = 1'b1;
        rowMissAvail       = 1'b0;
        dmaStatus          = '0;
        ch0Done            = 1'b0;
        chDone             = 3'h0;
        chTake             = 1'b0;
        chTakeSel          = 2'h0;
        on_demand_mode_bit = 1'b0;
        addrErrorClear     = 1'b0;
        tick(5);
        sys_rst = 1'b0;
        on_demand_mode_bit = 1'b1;
        check(32'({ch0Request, chPending, addr_error_flag, frozen}), 0);
        // first request after reset is a bare strobe
        u_ctrl.strobe_only(1'b0);
        tick(3);
        check(32'({ch0Request.valid, chPending}), 0);
        u_ctrl.send_cmd(32'h00000000);
        check(32'(ch0Request), 32'h4);
        check(32'(grants), 1);
        u_ctrl.send_cmd(32'h00000000);
        done0();
        tick(2);
        check(32'(ch0Request.valid), 0);
        dmaStatus.busCycle0 = 1'b1;
        u_ctrl.send_cmd(32'h00000000);
        tick(2);
        check(32'(ch0Request.valid), 0);
        dmaStatus.busCycle0 = 1'b0;
        u_ctrl.send_cmd(32'h01000000);
        tick(2);
        check(32'(addr_error_flag), 1);
        addrErrorClear = 1'b1;
        tick(1);
        addrErrorClear = 1'b0;
        tick(1);
        check(32'(addr_error_flag), 0);
        dmaStatus.running0 = 1'b1;
        u_ctrl.send_cmd(32'hE3000000);
        tick(2);
        check(32'(endClears), 0);
        dmaStatus.running0 = 1'b0;
        u_ctrl.send_cmd(32'hE1000000);
        tick(2);
        check(32'(endClears), 1);
        // fill each queue past its depth, then drain it
        for (int ch = 1; ch <= 3; ch++) begin
            for (int i = 0; i <= `QUEUE_DEPTH; i++) begin
                u_ctrl.send_cmd(32'hE3000000 | (32'(ch) << 26));
                tick(1);
                check(32'(chFull[ch-1]), 32'(i >= 3));
            end
            dmaStatus.xferEndFlag0 = 1'b1;
            pop(2'(ch), 1);
            check(32'({chPending[ch-1], chFull[ch-1]}), 32'h2);
            pop(2'(ch), `QUEUE_DEPTH - 1);
            check(32'(chPending), 0);
            dmaStatus.xferEndFlag0 = 1'b0;
        end
        // bare strobe repeats the most recent channel
        for (int i = 0; i < 3; i++) u_ctrl.send_cmd(32'h04000000);
        tick(3);
        u_ctrl.strobe_only(1'b0);
        tick(2);
        check(32'(chFull), 32'h1);
        g0 = grants;
        for (int i = 0; i < `QUEUE_DEPTH; i++) begin
            u_ctrl.strobe_only(1'b1);
            tick(3);
        end
        check(32'(chFull), 32'h3);
        check(32'(grants), 32'(g0));
        // row miss forces bus-available while the request is being taken
        u_ctrl.release_pulse();
        rowMissAvail = 1'b1;
        tick(2);
        rowMissAvail = 1'b0;
        tick(3);
        check(32'(grants), 32'(g0 + 2));
        u_ctrl.send_cmd(32'h00000000);
        u_ctrl.send_cmd(32'hC2000000);
        tick(2);
        check(32'(flushes), 1);
        check(32'({ch0Request.valid, chPending}), 0);
        // bare strobe to an ended channel 0 with its end flag still set
        u_ctrl.send_cmd(32'h00000000);
        dmaStatus.xferEndFlag0 = 1'b1;
        done0();
        tick(3);
        u_ctrl.strobe_only(1'b0);
        tick(2);
        check(32'(frozen), 1);
        dmaStatus.xferEndFlag0 = 1'b0;
        u_ctrl.send_cmd(32'hC2000000);
        tick(2);
        check(32'(frozen), 0);
        dmaStatus.anyRunning = 1'b1;
        on_demand_mode_bit = 1'b0;
        tick(2);
        check(32'(frozen), 1);
        dmaStatus.anyRunning = 1'b0;
        on_demand_mode_bit = 1'b1;
        tick(2);
        u_ctrl.send_cmd(32'hC2000000);
        tick(2);
        check(32'(frozen), 0);
        test_done();
    end
endmodule
